//--- common/ebm_consts.svh
// Constants for the external bus master: codes, widths, reset values
`ifndef EBM_CONSTS_SVH
`define EBM_CONSTS_SVH
`define EBM_ADDR_LO_W   20
`define EBM_ADDR_W      24
`define EBM_REPL_W      4
`define EBM_DATA_W      16
`define EBM_OPND_W      32
`define EBM_BYTE_W      8
`define EBM_REM_W       3
`define EBM_SYNC_W      21
`define EBM_FIFO_DEPTH  16
`define EBM_RSP_W       35
`define EBM_SIZE_BYTE   2'h1
`define EBM_SIZE_WORD   2'h2
`define EBM_SIZE_TRIPLE 2'h3
`define EBM_SIZE_LONG   2'h0
`define EBM_FC_TOP      1'h1
`define EBM_RW_READ     1'h1
`define EBM_STROBE_OFF  1'h1
`define EBM_ACK_WAIT    2'h3
`define EBM_ACK_8       2'h2
`define EBM_ACK_16      2'h1
`define EBM_ACK_RSVD    2'h0
`define EBM_REM_ZERO    3'h0
`define EBM_REM_ONE     3'h1
`define EBM_REM_TWO     3'h2
`define EBM_SYNC_IDLE   21'h1f_ffff
`endif

//--- common/ebm_pkg.sv
// Types shared by the external bus master files
package ebm_pkg;
   typedef enum logic [2:0] {
      EBM_IDLE,
      EBM_ADDR,
      EBM_ASRT,
      EBM_WDS,
      EBM_WAIT,
      EBM_ENDC,
      EBM_PUSH
   } ebm_state_type;
endpackage

//--- rtl/ebm_fifo.sv
// Response FIFO of flip-flops with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module ebm_fifo #(
   parameter int WIDTH = 35,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,       // System clock
   input  wire logic             rst,       // Synchronous reset
   input  wire logic             ce,        // Clock enable
   input  wire logic             in_valid,  // Write request
   output logic                  in_ready,  // Room available
   input  wire logic [WIDTH-1:0] in_data,   // Write data
   output logic                  out_valid, // Data available
   input  wire logic             out_ready, // Drain accepts
   output logic      [WIDTH-1:0] out_data   // Head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = ce && in_valid && in_ready;
   assign pop       = ce && out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

//--- rtl/ebm_master.sv
// External asynchronous bus master with dynamic bus sizing
`timescale 1ns/10ps
`default_nettype none
`include "ebm_consts.svh"

// Functional notes
// - Full mode: 24 address, 16 data, both ports
// - Partial mode: 8 data lines, byte ports only
// - Address lines 23:20 copy line 19
// - Address of most significant byte, held
// - Width code gives bytes left in operand
// - Direction line toggles only on direction change
// - Space code top bit always one
// - Location strobe asserted after cycle start
// - Read data captured at cycle end
// - Writes drive all sixteen data lines
// - Read: transfer strobe with location strobe
// - Write: transfer strobe one clock later
// - Port acknowledges end cycle, report width
// - Slave sets cycle length; master waits
// - Narrow ports: repeat cycles for operand
// - Fault input terminates cycle with error
// - Fault plus halt gives exception
// - Self vector ends only acknowledge cycles
// - Acknowledge pair decode: wait, 8, 16, reserved
module ebm_master #(
   parameter int FIFO_DEPTH = `EBM_FIFO_DEPTH
) (
   input  wire logic        clk,                     // System clock, 10 MHz
   input  wire logic        rst,                     // Synchronous reset
   input  wire logic        ce,                      // Clock enable
   input  wire logic        full_mode,               // 1 full, 0 partial expansion
   input  wire logic        req_valid,               // Transfer request
   output logic             req_ready,               // Request taken
   input  wire logic [19:0] req_addr,                // Operand address
   input  wire logic [2:0]  req_bytes,               // Operand bytes: 1, 2 or 4
   input  wire logic        req_write,               // 1 write, 0 read
   input  wire logic [1:0]  req_space,               // Low bits of space code
   input  wire logic        req_iack,                // Interrupt acknowledge cycle
   input  wire logic [31:0] req_wdata,               // Write operand, right aligned
   output logic             rsp_valid,               // Response available
   input  wire logic        rsp_ready,               // Response taken
   output logic [31:0]      rsp_rdata,               // Read operand, right aligned
   output logic             rsp_fault,               // Ended by fault
   output logic             rsp_exception,           // Fault with halt
   output logic             rsp_autovec,             // Ended by self vector
   output logic [23:0]      addr_out,                // Address lines
   output logic             width_code_high,         // Size code high bit
   output logic             width_code_low,          // Size code low bit
   output logic [2:0]       space_code,              // Address space code
   output logic             rw_out,                  // 1 read, 0 write
   output logic             location_valid_strobe_n, // Address strobe
   output logic             transfer_strobe_n,       // Data strobe
   input  wire logic [15:0] data_in,                 // Data bus input
   output logic [15:0]      data_out,                // Data bus output
   output logic             data_oe,                 // Data bus drive enable
   input  wire logic        port_ack_high_n,         // Port acknowledge high
   input  wire logic        port_ack_low_n,          // Port acknowledge low
   input  wire logic        fault_terminate_n,       // Bus fault input
   input  wire logic        halt_n,                  // Halt input
   input  wire logic        self_vector_ack_n        // Autovector input
);
   ebm_pkg::ebm_state_type state_q;
   logic [`EBM_SYNC_W-1:0]    s1_q;
   logic [`EBM_SYNC_W-1:0]    s2_q;
   logic [`EBM_SYNC_W-1:0]    s3_q;
   logic [`EBM_SYNC_W-1:0]    filt_q;
   logic [`EBM_DATA_W-1:0]    f_data;
   logic [1:0]                f_ack;
   logic                      f_fault_n;
   logic                      f_halt_n;
   logic                      f_self_vector_ack_n;
   logic [`EBM_ADDR_LO_W-1:0] addr_q;
   logic [`EBM_REM_W-1:0]     rem_q;
   logic [`EBM_REM_W-1:0]     nbytes_q;
   logic [`EBM_OPND_W-1:0]    opbuf_q;
   logic [`EBM_OPND_W-1:0]    rdbuf_q;
   logic                      write_q;
   logic                      iack_q;
   logic [1:0]                space_q;
   logic                      rw_q;
   logic                      fault_q;
   logic                      exc_q;
   logic                      self_vector_ack_q;
   logic [`EBM_DATA_W-1:0]    wdata_q;
   logic                      ack_done;
   logic                      port16;
   logic [`EBM_REM_W-1:0]     nb;
   logic                      term_fault;
   logic                      term_self_vector_ack;
   logic                      inputs_idle;
   logic                      fifo_in_ready;
   logic [`EBM_RSP_W-1:0]     fifo_out;

   // Bytes moved by one cycle for the port that answered
   function automatic logic [`EBM_REM_W-1:0] xfer_bytes(input logic [`EBM_REM_W-1:0] rem,
                                                       input logic a0, input logic wide);
      logic [`EBM_REM_W-1:0] n;
      n = `EBM_REM_ONE;
      if (wide && !a0 && (rem >= `EBM_REM_TWO)) begin
         n = `EBM_REM_TWO;
      end
      return n;
   endfunction

   // Three-stage input synchroniser; filter needs stages 2 and 3 to agree
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= `EBM_SYNC_IDLE;
         s2_q <= `EBM_SYNC_IDLE;
         s3_q <= `EBM_SYNC_IDLE;
      end else if (ce) begin
         s1_q <= {data_in, port_ack_high_n, port_ack_low_n, fault_terminate_n, halt_n, self_vector_ack_n};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `EBM_SYNC_W; gi++) begin : g_filt
         always_ff @(posedge clk) begin
            if (rst) begin
               filt_q[gi] <= `EBM_STROBE_OFF;
            end else if (ce && (s2_q[gi] == s3_q[gi])) begin
               filt_q[gi] <= s3_q[gi];
            end
         end
      end
   endgenerate

   assign f_data    = filt_q[`EBM_SYNC_W-1 -: `EBM_DATA_W];
   assign f_ack     = filt_q[4:3];
   assign f_fault_n = filt_q[2];
   assign f_halt_n  = filt_q[1];
   assign f_self_vector_ack_n  = filt_q[0];

   // Partial mode treats every completion as a byte port
   assign port16      = (f_ack == `EBM_ACK_16) && full_mode;
   assign ack_done    = (f_ack == `EBM_ACK_16) || (f_ack == `EBM_ACK_8);
   assign term_fault  = !f_fault_n;
   assign term_self_vector_ack   = iack_q && !f_self_vector_ack_n;
   assign nb          = xfer_bytes(rem_q, addr_q[0], port16);
   // A new cycle starts only after the slave has released its terminations
   assign inputs_idle = (f_ack == `EBM_ACK_WAIT) && f_fault_n && f_self_vector_ack_n;
   assign req_ready   = (state_q == ebm_pkg::EBM_IDLE) && fifo_in_ready;

   // Sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ebm_pkg::EBM_IDLE;
      end else if (ce) begin
         unique case (state_q)
            ebm_pkg::EBM_IDLE: begin
               if (req_valid && req_ready) begin
                  state_q <= ebm_pkg::EBM_ADDR;
               end
            end
            ebm_pkg::EBM_ADDR: begin
               if (inputs_idle) begin
                  state_q <= ebm_pkg::EBM_ASRT;
               end
            end
            ebm_pkg::EBM_ASRT: begin
               state_q <= write_q ? ebm_pkg::EBM_WDS : ebm_pkg::EBM_WAIT;
            end
            ebm_pkg::EBM_WDS: begin
               state_q <= ebm_pkg::EBM_WAIT;
            end
            ebm_pkg::EBM_WAIT: begin
               if (term_fault || term_self_vector_ack || ack_done) begin
                  state_q <= ebm_pkg::EBM_ENDC;
               end
            end
            ebm_pkg::EBM_ENDC: begin
               if (fault_q || self_vector_ack_q || (rem_q == `EBM_REM_ZERO)) begin
                  state_q <= ebm_pkg::EBM_PUSH;
               end else begin
                  state_q <= ebm_pkg::EBM_ADDR;
               end
            end
            ebm_pkg::EBM_PUSH: begin
               if (fifo_in_ready) begin
                  state_q <= ebm_pkg::EBM_IDLE;
               end
            end
         endcase
      end
   end

   // Operand, address and remaining count
   always_ff @(posedge clk) begin
      if (rst) begin
         addr_q   <= '0;
         rem_q    <= `EBM_REM_ZERO;
         nbytes_q <= `EBM_REM_ZERO;
         opbuf_q  <= '0;
         write_q  <= 1'b0;
         iack_q   <= 1'b0;
         space_q  <= '0;
      end else if (ce) begin
         if (state_q == ebm_pkg::EBM_IDLE && req_valid && req_ready) begin
            addr_q   <= req_addr;
            rem_q    <= req_bytes;
            nbytes_q <= req_bytes;
            opbuf_q  <= req_wdata << (`EBM_BYTE_W * (`EBM_OPND_W / `EBM_BYTE_W - 32'(req_bytes)));
            write_q  <= req_write && !req_iack;
            iack_q   <= req_iack;
            space_q  <= req_space;
         end else if (state_q == ebm_pkg::EBM_WAIT && ack_done && !term_fault && !term_self_vector_ack) begin
            addr_q <= addr_q + `EBM_ADDR_LO_W'(nb);
            rem_q  <= rem_q - nb;
            if (nb == `EBM_REM_TWO) begin
               opbuf_q <= {opbuf_q[15:0], 16'h0000};
            end else begin
               opbuf_q <= {opbuf_q[23:0], 8'h00};
            end
         end
      end
   end

   // Read assembly and termination status
   always_ff @(posedge clk) begin
      if (rst) begin
         rdbuf_q <= '0;
         fault_q <= 1'b0;
         exc_q   <= 1'b0;
         self_vector_ack_q  <= 1'b0;
      end else if (ce) begin
         if (state_q == ebm_pkg::EBM_IDLE) begin
            rdbuf_q <= '0;
            fault_q <= 1'b0;
            exc_q   <= 1'b0;
            self_vector_ack_q  <= 1'b0;
         end else if (state_q == ebm_pkg::EBM_WAIT) begin
            if (term_fault) begin
               fault_q <= 1'b1;
               exc_q   <= !f_halt_n;
            end else if (term_self_vector_ack) begin
               self_vector_ack_q <= 1'b1;
            end else if (ack_done && !write_q) begin
               if (nb == `EBM_REM_TWO) begin
                  rdbuf_q <= {rdbuf_q[15:0], f_data};
               end else if (port16 && addr_q[0]) begin
                  rdbuf_q <= {rdbuf_q[23:0], f_data[7:0]};
               end else begin
                  rdbuf_q <= {rdbuf_q[23:0], f_data[15:8]};
               end
            end
         end
      end
   end

   // Direction line keeps its level unless the next cycle reverses it
   always_ff @(posedge clk) begin
      if (rst) begin
         rw_q <= `EBM_RW_READ;
      end else if (ce && state_q == ebm_pkg::EBM_IDLE && req_valid && req_ready) begin
         rw_q <= !(req_write && !req_iack);
      end
   end

   // Write data: byte is copied to both halves so either port width finds it
   always_ff @(posedge clk) begin
      if (rst) begin
         wdata_q <= '0;
      end else if (ce && state_q == ebm_pkg::EBM_ADDR) begin
         if (addr_q[0] || rem_q == `EBM_REM_ONE) begin
            wdata_q <= {opbuf_q[31:24], opbuf_q[31:24]};
         end else begin
            wdata_q <= opbuf_q[31:16];
         end
      end
   end

   // Bus pins from flip-flops
   always_ff @(posedge clk) begin
      if (rst) begin
         location_valid_strobe_n <= `EBM_STROBE_OFF;
         transfer_strobe_n       <= `EBM_STROBE_OFF;
         data_oe                 <= 1'b0;
      end else if (ce) begin
         unique case (state_q)
            ebm_pkg::EBM_ADDR: begin
               location_valid_strobe_n <= !inputs_idle ? `EBM_STROBE_OFF : 1'b0;
               transfer_strobe_n       <= !inputs_idle || write_q;
               data_oe                 <= inputs_idle && write_q;
            end
            ebm_pkg::EBM_ASRT: begin
               data_oe <= write_q;
               if (write_q) begin
                  transfer_strobe_n <= 1'b0;
               end
            end
            ebm_pkg::EBM_WAIT: begin
               if (term_fault || term_self_vector_ack || ack_done) begin
                  location_valid_strobe_n <= `EBM_STROBE_OFF;
                  transfer_strobe_n       <= `EBM_STROBE_OFF;
                  data_oe                 <= 1'b0;
               end
            end
            default: begin
               location_valid_strobe_n <= location_valid_strobe_n;
            end
         endcase
      end
   end

   assign addr_out        = {{`EBM_REPL_W{addr_q[19]}}, addr_q};
   assign width_code_high = rem_q[1];
   assign width_code_low  = rem_q[0];
   assign space_code      = {`EBM_FC_TOP, iack_q ? 2'h3 : space_q};
   assign rw_out          = rw_q;
   assign data_out        = wdata_q;

   ebm_fifo #(
      .WIDTH (`EBM_RSP_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rsp_fifo (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .in_valid  (state_q == ebm_pkg::EBM_PUSH),
      .in_ready  (fifo_in_ready),
      .in_data   ({exc_q, fault_q, self_vector_ack_q, rdbuf_q}),
      .out_valid (rsp_valid),
      .out_ready (rsp_ready),
      .out_data  (fifo_out)
   );

   assign rsp_exception = fifo_out[34];
   assign rsp_fault     = fifo_out[33];
   assign rsp_autovec   = fifo_out[32];
   assign rsp_rdata     = fifo_out[31:0];
endmodule
`default_nettype wire

//--- dv/ebm_master_properties.sv
// Concurrent checks on the bus master's pins and request side
`timescale 1ns/10ps
`default_nettype none
module ebm_master_properties #(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic        clk,                     // System clock
   input wire logic        rst,                     // Sync reset
   input wire logic        req_ready,               // Request taken
   input wire logic        rsp_valid,               // Response ready
   input wire logic        rsp_fault,               // Fault ending
   input wire logic        rsp_autovec,             // Self vector ending
   input wire logic [23:0] addr_out,                // Address lines
   input wire logic        width_code_high,         // Size high
   input wire logic        width_code_low,          // Size low
   input wire logic [2:0]  space_code,              // Space code
   input wire logic        rw_out,                  // Direction
   input wire logic        location_valid_strobe_n, // Address strobe
   input wire logic        transfer_strobe_n,       // Data strobe
   input wire logic        data_oe,                 // Data drive
   input wire logic        port_ack_high_n,         // Ack high
   input wire logic        port_ack_low_n,          // Ack low
   input wire logic        fault_terminate_n,       // Fault input
   input wire logic        self_vector_ack_n        // Self vector input
);
   logic [3:0] idle_cnt;
   logic [3:0] term_cnt;
   logic       term;
   // Reserved and wait codes both leave the cycle running
   assign term = !fault_terminate_n || (port_ack_high_n != port_ack_low_n);
   always_ff @(posedge clk) begin
      if (rst || term || !self_vector_ack_n) idle_cnt <= 4'h0;
      else if (idle_cnt != 4'hf) idle_cnt <= idle_cnt + 4'h1;
   end
   always_ff @(posedge clk) begin
      if (rst || !term || location_valid_strobe_n) term_cnt <= 4'h0;
      else if (term_cnt != 4'hf) term_cnt <= term_cnt + 4'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_ADDR_REPL: assert property (addr_out[23:20] == {4{addr_out[19]}})
      else $error("upper address differs from line 19");
   AST_SPACE_TOP: assert property (space_code[2])
      else $error("space code top bit low");
   AST_CTRL_HOLD: assert property (!location_valid_strobe_n && !$past(location_valid_strobe_n) |->
      $stable({addr_out, width_code_high, width_code_low, space_code, rw_out}))
      else $error("controls moved under strobe");
   AST_RW_CHANGE: assert property ($changed(rw_out) |-> location_valid_strobe_n && $past(location_valid_strobe_n))
      else $error("direction changed inside a cycle");
   AST_READ_DS: assert property ($fell(location_valid_strobe_n) && rw_out |-> !transfer_strobe_n)
      else $error("read strobes not together");
   AST_WRITE_DS: assert property ($fell(location_valid_strobe_n) && !rw_out |-> transfer_strobe_n ##1 !transfer_strobe_n)
      else $error("write strobe not one late");
   AST_WRITE_OE: assert property ($fell(location_valid_strobe_n) && !rw_out |-> data_oe)
      else $error("write data not driven");
   AST_OE_DIR: assert property (data_oe |-> !rw_out && !location_valid_strobe_n)
      else $error("data driven outside write");
   AST_NO_TERM_WAIT: assert property (!location_valid_strobe_n && idle_cnt >= 4'h6 |=> !location_valid_strobe_n)
      else $error("cycle ended unterminated");
   AST_TERM_ENDS: assert property (term_cnt <= 4'h6)
      else $error("strobes held after termination");
   AST_BUSY_REFUSE: assert property (!location_valid_strobe_n |-> !req_ready)
      else $error("request taken in cycle");
   cover property ($fell(transfer_strobe_n) && !rw_out);
   cover property ($fell(location_valid_strobe_n) && rw_out);
   cover property (rsp_valid && rsp_fault);
   cover property (rsp_valid && rsp_autovec);
endmodule
bind ebm_master ebm_master_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.*);
`default_nettype wire

//--- dv/ebm_slave_model.sv
// Behavioural external memory answering the bus master's cycles
`timescale 1ns/10ps
`default_nettype none
module ebm_slave_model (
   input  wire logic        clk,                     // System clock
   input  wire logic        clr,                     // Clear cycle count
   input  wire logic        wide,                    // 1 answers as 16-bit port
   input  wire logic [1:0]  mode,                    // 0 ack, 1 fault, 2 self vector
   input  wire logic [3:0]  dly,                     // Wait states
   input  wire logic [23:0] addr_out,                // Address lines
   input  wire logic        width_code_high,         // Size high
   input  wire logic        width_code_low,          // Size low
   input  wire logic [2:0]  space_code,              // Space code
   input  wire logic        rw_out,                  // 1 read
   input  wire logic        location_valid_strobe_n, // Address strobe
   input  wire logic        transfer_strobe_n,       // Data strobe
   input  wire logic [15:0] data_out,                // Write data
   output logic      [15:0] data_in,                 // Read data
   output logic             port_ack_high_n,         // Ack high
   output logic             port_ack_low_n,          // Ack low
   output logic             fault_terminate_n,       // Fault
   output logic             self_vector_ack_n,       // Self vector
   output logic      [7:0]  cyc,                     // Cycles since clear
   output logic      [23:0] first_addr,              // Address of first cycle
   output logic      [1:0]  first_size               // Size of first cycle
);
   logic [7:0] mem [256];
   logic [7:0] a;
   logic [3:0] cnt;
   logic       done;
   logic       as_q;
   assign a = addr_out[7:0];
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'ha5;
      {port_ack_high_n, port_ack_low_n, fault_terminate_n, self_vector_ack_n, as_q} = 5'h1f;
      {data_in, cyc, cnt, done} = '0;
   end
   always @(posedge clk) begin
      as_q <= location_valid_strobe_n;
      if (clr) cyc <= 8'h00;
      else if (as_q && !location_valid_strobe_n) begin
         cyc <= cyc + 8'h01;
         if (cyc == 8'h00) {first_addr, first_size} <= {addr_out, width_code_high, width_code_low};
      end
      // Unselected: lines toggle, not hold
      data_in <= ~data_in;
      if (!transfer_strobe_n && rw_out)
         data_in <= !wide ? {mem[a], ~mem[a]} : addr_out[0] ? {~mem[a], mem[a]} : {mem[a], mem[8'(a + 1)]};
      if (location_valid_strobe_n) begin
         {cnt, done} <= '0;
         {port_ack_high_n, port_ack_low_n, fault_terminate_n, self_vector_ack_n} <= 4'hf;
      end else if (!done && (rw_out || !transfer_strobe_n)) begin
         if (cnt != dly) cnt <= cnt + 4'h1;
         else begin
            done <= 1'b1;
            if (mode == 2'h1) fault_terminate_n <= 1'b0;
            else begin
               if (mode == 2'h2) self_vector_ack_n <= 1'b0;
               if (mode == 2'h0 || space_code != 3'h7) {port_ack_high_n, port_ack_low_n} <= wide ? 2'b01 : 2'b10;
            end
            if (mode == 2'h0 && !rw_out) begin
               if (!wide || !addr_out[0]) mem[a] <= data_out[15:8];
               else mem[a] <= data_out[7:0];
               if (wide && !addr_out[0] && {width_code_high, width_code_low} != 2'h1) mem[8'(a + 1)] <= data_out[7:0];
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- dv/ebm_master_test.sv
// Self-checking bench: random and corner transfers through the bus master
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin err_count++; $display("CHECK FAILED %0t %s", $time, m); end end
module ebm_master_test;
   typedef struct packed {
      logic [31:0] d;
      logic [19:0] a;
      logic [1:0]  s;
      logic [2:0]  p;
      logic [7:0]  c;
      logic        f, x, v;
   } ebm_exp_type;
   logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, full_mode = 1'b1, halt_n = 1'b1, wide = 1'b1, clr = 1'b0;
   logic        req_valid = 1'b0, req_write = 1'b0, req_iack = 1'b0, rsp_ready = 1'b0;
   logic [19:0] req_addr = 20'h0_0000;
   logic [2:0]  req_bytes = 3'h1;
   logic [1:0]  req_space = 2'h1, mode = 2'h0;
   logic [3:0]  dly = 4'h0;
   logic [31:0] req_wdata = 32'h0000_0000, rsp_rdata;
   logic        req_ready, rsp_valid, rsp_fault, rsp_exception, rsp_autovec, rw_out, data_oe;
   logic        width_code_high, width_code_low, location_valid_strobe_n, transfer_strobe_n;
   logic        port_ack_high_n, port_ack_low_n, fault_terminate_n, self_vector_ack_n;
   logic [23:0] addr_out, first_addr;
   logic [2:0]  space_code;
   logic [15:0] data_in, data_out;
   logic [7:0]  cyc;
   logic [1:0]  first_size;
   logic [7:0]  refm [256];
   ebm_exp_type q[$];
   integer      err_count = 0, comparisons = 0, seed = 32'h89e8_f5b3;
   ebm_master dut (.*);
   ebm_slave_model far (.*);
   initial forever #50 clk = ~clk;
   task automatic step;
      @(posedge clk);
      #1;
   endtask
   task automatic results;
      if (err_count == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic expire;
      err_count++;
      $display("CHECK FAILED %0t wait limit", $time);
      results;
   endtask
   // Bus cycles per operand, largest aligned piece first
   function automatic logic [7:0] ncyc(logic [19:0] a, int n, logic w);
      logic [7:0] c;
      c = 8'h00;
      while (n > 0) begin
         if (w && !a[0] && n > 1) begin n -= 2; a += 20'h2; end
         else begin n--; a += 20'h1; end
         c++;
      end
      return c;
   endfunction
   task automatic issue(logic [19:0] a, logic [2:0] n, logic wr, logic ia, logic [31:0] wd, logic chk);
      ebm_exp_type e;
      int          k;
      e = '0;
      for (k = 0; k < n; k++) begin
         if (!wr) e.d = {e.d[23:0], refm[8'(a + k)]};
         else if (mode == 2'h0) refm[8'(a + k)] = wd[8 * (n - 1 - k) +: 8];
      end
      req_space = 2'($unsigned($random(seed)) % 3);
      {e.a, e.s, e.f, e.p} = {a, n[1:0], mode == 2'h1, 1'b1, (ia ? 2'h3 : req_space)};
      e.x = e.f && !halt_n;
      e.v = mode == 2'h2 && ia;
      e.c = !chk ? 8'h00 : (e.f || e.v) ? 8'h01 : ncyc(a, n, wide && full_mode);
      q.push_back(e);
      clr = 1'b1;
      step;
      clr = 1'b0;
      {req_addr, req_bytes, req_write, req_iack, req_wdata} = {a, n, wr, ia, wd};
      req_valid = 1'b1;
      k = 0;
      while (req_ready !== 1'b1) begin
         step;
         k++;
         if (k > 500) expire;
      end
      step;
      req_valid = 1'b0;
   endtask
   task automatic pop;
      ebm_exp_type e;
      int          k;
      e = q.pop_front();
      k = 0;
      while (rsp_valid !== 1'b1) begin
         step;
         k++;
         if (k > 2000) expire;
      end
      `CHK(rsp_fault, e.f, "fault flag")
      `CHK(rsp_exception, e.x, "exception flag")
      `CHK(rsp_autovec, e.v, "self vector flag")
      if (!e.f && !e.v) `CHK(rsp_rdata, e.d, "read operand")
      if (e.c != 8'h00) begin
         `CHK(cyc, e.c, "bus cycle count")
         `CHK(first_addr, {{4{e.a[19]}}, e.a}, "first address")
         `CHK(first_size, e.s, "first size code")
         `CHK(space_code, e.p, "space code")
      end
      rsp_ready = 1'b1;
      step;
      rsp_ready = 1'b0;
      step;
   endtask
   initial begin
      int         i;
      logic [2:0] n;
      for (i = 0; i < 256; i++) refm[i] = 8'(i) ^ 8'ha5;
      repeat (3) step;
      rst = 1'b0;
      // Odd long word at the top of the space: wraps and splits
      for (i = 0; i < 4; i++) begin
         wide = i[0];
         issue(20'hf_fffd, 3'h4, !i[1], 1'b0, 32'h1234_5678 + i, 1'b1);
         pop;
      end
      for (i = 0; i < 60; i++) begin
         full_mode = 1'($random(seed));
         wide = full_mode & 1'($random(seed));
         dly = 4'($random(seed)) & 4'h3;
         n = 3'h1 << ($unsigned($random(seed)) % 3);
         issue(20'($random(seed)), n, 1'($random(seed)), 1'b0, $random(seed), 1'b1);
         pop;
      end
      // Fault with and without halt, then self vector in and out of acknowledge cycles
      {dly, full_mode, wide} = {4'h2, 2'b11};
      for (i = 0; i < 6; i++) begin
         mode = (i < 4) ? 2'h1 : 2'h2;
         halt_n = !i[0];
         issue(20'h0_1234 + 20'(i), 3'h2, i < 2, i == 4, 32'h0000_a55a, 1'b1);
         pop;
      end
      {mode, halt_n, dly} = {2'h0, 1'b1, 4'h3};
      for (i = 0; i < 16; i++) issue(20'($random(seed)), 3'h2, 1'b0, 1'b0, 32'h0000_0000, 1'b0);
      repeat (100) step;
      `CHK(req_ready, 1'b0, "full buffer ready")
      for (i = 0; i < 16; i++) pop;
      `CHK(rsp_valid, 1'b0, "drained still valid")
      results;
   end
endmodule
`default_nettype wire
